// ==== rtl/csk_decode.sv ====
// compare-with-working-register-and-skip decoder and executor with apb registers
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/1ps
`include "csk_map.svh"

module csk_decode
	import csk_pkg::*;
#(
	parameter int BANK_W = 6, // bank select width
	parameter logic [BANK_W-1:0] ACC_HI_BANK = '1 // bank of upper access half
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [BANK_W+7:0] mem_addr, // data memory byte address
	output logic mem_rd, // read strobe, high in q2
	input wire logic [7:0] mem_rdata, // valid the clock after mem_rd
	output logic [1:0] q_phase, // current q phase, 0 = q1
	output logic busy, // instruction in flight
	output logic nop_cycle, // forced no-operation cycle
	output logic skip, // last compare result
	output logic done // one-clock end pulse
);

	// ***************************************************************
	// elaboration checks
	// ***************************************************************
	if (BANK_W < 4 || BANK_W > 16)
	begin : g_chk
		$error("csk_decode: BANK_W out of range");
	end

	localparam int AW = BANK_W + 8;

	// ***************************************************************
	// functions
	// ***************************************************************
	// unsigned compare; the difference itself is never kept
	function automatic logic csk_cmp(input csk_kind_t k, input logic [7:0] f, input logic [7:0] w);
		logic [8:0] diff;
		diff = {1'b0, f} - {1'b0, w};
		unique case (k)
			CSK_K_GT: csk_cmp = !diff[8] && (diff[7:0] != 8'h00);
			CSK_K_LT: csk_cmp = diff[8];
			CSK_K_EQ: csk_cmp = (diff[7:0] == 8'h00);
			default: csk_cmp = 1'b0;
		endcase
	endfunction : csk_cmp

	// opcode class from the upper byte
	function automatic csk_kind_t csk_kind(input logic [15:0] ins);
		if (ins[15:9] == `CSK_OP_GT) csk_kind = CSK_K_GT;
		else if (ins[15:9] == `CSK_OP_LT) csk_kind = CSK_K_LT;
		else if (ins[15:9] == `CSK_OP_EQ) csk_kind = CSK_K_EQ;
		else csk_kind = CSK_K_BAD;
	endfunction : csk_kind

	// effective data address of the file operand
	function automatic logic [AW-1:0] csk_addr(input logic [15:0] ins, input logic ext,
		input logic [BANK_W-1:0] bnk, input logic [AW-1:0] idx);
		logic [7:0] f;
		f = ins[7:0];
		if (ins[`CSK_INSTR_A])
			csk_addr = {bnk, f};
		else if (ext && f <= `CSK_IDX_LIMIT)
			csk_addr = AW'(idx + {{BANK_W{1'b0}}, f});
		else if (f < `CSK_ACC_SPLIT)
			csk_addr = {{BANK_W{1'b0}}, f};
		else
			csk_addr = {ACC_HI_BANK, f};
	endfunction : csk_addr

	// ***************************************************************
	// registers
	// ***************************************************************
	logic [15:0] instr_r; // instruction word under test
	logic [7:0] work_r, data_r; // working register copy and the byte read in q2
	logic [BANK_W-1:0] bank_r; // bank select register
	logic [AW-1:0] index_r, mem_addr_r; // index base for literal offset mode, latched data address
	logic [1:0] words_r; // word length of the following instruction
	logic ext_r, start_r; // extended instruction set enable, one-clock start request
	logic done_flag_r, bad_r; // sticky completion flag, opcode was not a compare-skip
	logic [3:0] cyc_r; // instruction cycles used
	csk_kind_t kind_r; // class latched at decode
	csk_state_t state_r; // sequencer state
	logic [1:0] q_r, nop_left_r; // q phase and nop cycles still to run
	logic mem_rd_r, busy_r, nop_r, skip_r, done_r; // flopped status outputs
	logic [31:0] prdata_r; // registered read data
	logic pready_r, pslverr_r; // registered bus answer

	// ***************************************************************
	// apb decode
	// ***************************************************************
	wire access_w = psel && penable && !pready_r; // first access clock
	wire commit_w = psel && penable && pready_r; // completing edge
	wire wr_w = commit_w && pwrite;
	wire sel_ctrl = (paddr == `CSK_OFF_CTRL);
	wire sel_instr = (paddr == `CSK_OFF_INSTR);
	wire sel_work = (paddr == `CSK_OFF_WORK);
	wire sel_bank = (paddr == `CSK_OFF_BANK);
	wire sel_index = (paddr == `CSK_OFF_INDEX);
	wire sel_next = (paddr == `CSK_OFF_NEXT);
	wire sel_stat = (paddr == `CSK_OFF_STAT);
	wire mapped_w = sel_ctrl || sel_instr || sel_work || sel_bank || sel_index || sel_next || sel_stat;
	// operand registers are frozen while an instruction runs
	wire cfg_wr_w = wr_w && !busy_r;
	wire [31:0] stat_w = {20'h0_0000, cyc_r, 4'h0, bad_r, skip_r, done_flag_r, busy_r};
	wire [31:0] rmux_w = sel_ctrl ? {30'h0000_0000, ext_r, 1'b0} :
		sel_instr ? {16'h0000, instr_r} :
		sel_work ? {24'h00_0000, work_r} :
		sel_bank ? 32'(bank_r) :
		sel_index ? 32'(index_r) :
		sel_next ? {30'h0000_0000, words_r} :
		sel_stat ? stat_w : 32'h0000_0000;

	// one wait state: pready and read data rise together
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end
		else
		begin
			pready_r <= access_w;
			pslverr_r <= access_w && !mapped_w;
			prdata_r <= (access_w && !pwrite) ? rmux_w : 32'h0000_0000;
		end
	end

	// software-written configuration
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			instr_r <= 16'h0000;
			work_r <= 8'h00;
			bank_r <= '0;
			index_r <= '0;
			words_r <= `CSK_RST_WORDS;
			ext_r <= 1'b0;
			start_r <= 1'b0;
		end
		else
		begin
			start_r <= cfg_wr_w && sel_ctrl && pwdata[`CSK_CTRL_START];
			if (cfg_wr_w && sel_ctrl) ext_r <= pwdata[`CSK_CTRL_EXT];
			if (cfg_wr_w && sel_instr) instr_r <= pwdata[15:0];
			if (cfg_wr_w && sel_work) work_r <= pwdata[7:0];
			if (cfg_wr_w && sel_bank) bank_r <= pwdata[BANK_W-1:0];
			if (cfg_wr_w && sel_index) index_r <= pwdata[AW-1:0];
			// zero words is taken as one, the shortest instruction
			if (cfg_wr_w && sel_next) words_r <= (pwdata[1:0] == 2'h0) ? 2'h1 : pwdata[1:0];
		end
	end

	// ***************************************************************
	// sequencer
	// ***************************************************************
	wire q_end_w = (q_r == `CSK_Q_LAST); // last clock of a cycle
	wire go_w = (state_r == CSK_IDLE) && start_r;
	wire in_q1_w = (state_r == CSK_EXEC) && (q_r == 2'h0);
	wire in_q2_w = (state_r == CSK_EXEC) && (q_r == 2'h1);
	wire in_q3_w = (state_r == CSK_EXEC) && (q_r == 2'h2);
	wire exec_end_w = (state_r == CSK_EXEC) && q_end_w;
	wire nop_end_w = (state_r == CSK_NOP) && q_end_w && (nop_left_r == 2'h1);
	wire fin_w = (exec_end_w && !skip_r) || nop_end_w;
	wire clr_done_w = wr_w && sel_stat && pwdata[`CSK_STAT_DONE];

	// state, q phase and the nop budget
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= CSK_IDLE;
			q_r <= 2'h0;
			nop_left_r <= 2'h0;
		end
		else
		begin
			q_r <= (state_r == CSK_IDLE) ? 2'h0 : 2'(q_r + 2'h1);
			unique case (state_r)
				CSK_IDLE: if (go_w) state_r <= CSK_EXEC;
				CSK_EXEC:
				begin
					// the prefetched word is dropped, nops stand in
					if (exec_end_w && skip_r)
					begin
						state_r <= CSK_NOP;
						nop_left_r <= words_r;
					end
					else if (exec_end_w)
						state_r <= CSK_IDLE;
				end
				CSK_NOP:
				begin
					if (q_end_w) nop_left_r <= 2'(nop_left_r - 2'h1);
					if (nop_end_w) state_r <= CSK_IDLE;
				end
			endcase
		end
	end

	// q1 decode, q2 read, q3 compare, q4 no write
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			kind_r <= CSK_K_BAD;
			mem_rd_r <= 1'b0;
			mem_addr_r <= '0;
			data_r <= 8'h00;
			skip_r <= 1'b0;
		end
		else
		begin
			mem_rd_r <= in_q1_w;
			if (in_q1_w)
			begin
				kind_r <= csk_kind(instr_r);
				mem_addr_r <= csk_addr(instr_r, ext_r, bank_r, index_r);
			end
			if (go_w) skip_r <= 1'b0;
			// compare in q3; nothing is written back in q4
			if (in_q3_w)
			begin
				data_r <= mem_rdata;
				skip_r <= csk_cmp(kind_r, mem_rdata, work_r);
			end
		end
	end

	// status: busy, nop marker, cycle count, sticky done
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			busy_r <= 1'b0;
			nop_r <= 1'b0;
			done_r <= 1'b0;
			done_flag_r <= 1'b0;
			bad_r <= 1'b0;
			cyc_r <= 4'h0;
		end
		else
		begin
			busy_r <= (busy_r && !fin_w) || go_w;
			nop_r <= (state_r == CSK_NOP) ? !nop_end_w : (exec_end_w && skip_r);
			done_r <= fin_w;
			// set wins over the software clear
			done_flag_r <= fin_w || (done_flag_r && !clr_done_w && !go_w);
			if (go_w) cyc_r <= 4'h0;
			else if ((state_r != CSK_IDLE) && q_end_w) cyc_r <= 4'(cyc_r + 4'h1);
			if (go_w) bad_r <= 1'b0;
			else if (in_q2_w) bad_r <= (kind_r == CSK_K_BAD);
		end
	end

	// ***************************************************************
	// outputs
	// ***************************************************************
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign mem_addr = mem_addr_r;
	assign mem_rd = mem_rd_r;
	assign q_phase = q_r;
	assign busy = busy_r;
	assign nop_cycle = nop_r;
	assign skip = skip_r;
	assign done = done_r;

	// ***************************************************************
	// assertions
	// ***************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// clocks spent per instruction, for the cycle-count check
	logic [4:0] clk_cnt_r;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn) clk_cnt_r <= 5'h00;
		else if (go_w) clk_cnt_r <= 5'h00;
		else if (busy_r) clk_cnt_r <= 5'(clk_cnt_r + 5'h01);
	end
	sequence s_exec_q1; in_q1_w; endsequence
	sequence s_read_q2; mem_rd_r && (state_r == CSK_EXEC) && (q_r == 2'h1); endsequence
	property p_gt_dec; s_exec_q1 ##0 (instr_r[15:9] == `CSK_OP_GT) |=> kind_r == CSK_K_GT; endproperty
	a_gt_dec: assert property (p_gt_dec) else $error("greater opcode not decoded");
	property p_lt_dec; s_exec_q1 ##0 (instr_r[15:9] == `CSK_OP_LT) |=> kind_r == CSK_K_LT; endproperty
	a_lt_dec: assert property (p_lt_dec) else $error("less opcode not decoded");
	property p_gt_skip; in_q3_w && kind_r == CSK_K_GT |=> skip_r == (data_r > work_r); endproperty
	a_gt_skip: assert property (p_gt_skip) else $error("greater skip wrong");
	property p_lt_skip; in_q3_w && kind_r == CSK_K_LT |=> skip_r == (data_r < work_r); endproperty
	a_lt_skip: assert property (p_lt_skip) else $error("less skip wrong");
	property p_eq_skip; in_q3_w && kind_r == CSK_K_EQ |=> skip_r == (data_r == work_r); endproperty
	a_eq_skip: assert property (p_eq_skip) else $error("equal skip wrong");
	property p_work_kept; busy_r |=> $stable(work_r) && $stable(instr_r); endproperty
	a_work_kept: assert property (p_work_kept) else $error("operands changed in flight");
	property p_bank_sel; s_exec_q1 ##0 instr_r[`CSK_INSTR_A]
		|=> mem_addr_r == {bank_r, instr_r[7:0]}; endproperty
	a_bank_sel: assert property (p_bank_sel) else $error("bank select address wrong");
	property p_index; s_exec_q1 ##0 (!instr_r[`CSK_INSTR_A] && ext_r && instr_r[7:0] <= `CSK_IDX_LIMIT)
		|=> mem_addr_r == AW'(index_r + {{BANK_W{1'b0}}, instr_r[7:0]}); endproperty
	a_index: assert property (p_index) else $error("indexed address wrong");
	property p_cycles; done_r |-> clk_cnt_r == 5'(4 * cyc_r)
		&& cyc_r == (skip_r ? 4'(words_r) + 4'h1 : 4'h1); endproperty
	a_cycles: assert property (p_cycles) else $error("instruction cycle count wrong");
	property p_nop_quiet; (state_r == CSK_NOP) |-> !mem_rd_r && nop_r; endproperty
	a_nop_quiet: assert property (p_nop_quiet) else $error("nop cycle not idle");
	property p_phases; s_exec_q1 |=> s_read_q2
		##1 (!mem_rd_r && q_r == 2'h2) ##1 (!mem_rd_r && q_r == 2'h3); endproperty
	a_phases: assert property (p_phases) else $error("q phase order wrong");

endmodule : csk_decode

// ==== rtl/csk_map.svh ====
// offsets, field positions, reset values and timing counts of the compare-skip decoder
`ifndef CSK_MAP_SVH
`define CSK_MAP_SVH

// ***************************************************************
// register byte offsets
// ***************************************************************
`define CSK_OFF_CTRL 12'h000
`define CSK_OFF_INSTR 12'h004
`define CSK_OFF_WORK 12'h008
`define CSK_OFF_BANK 12'h00C
`define CSK_OFF_INDEX 12'h010
`define CSK_OFF_NEXT 12'h014
`define CSK_OFF_STAT 12'h018

// ***************************************************************
// field positions
// ***************************************************************
`define CSK_CTRL_START 0
`define CSK_CTRL_EXT 1
`define CSK_STAT_BUSY 0
`define CSK_STAT_DONE 1
`define CSK_STAT_SKIP 2
`define CSK_STAT_BAD 3
`define CSK_STAT_CYC_LO 8
`define CSK_INSTR_A 8

// ***************************************************************
// opcodes: upper byte bits 7..1, bank-access bit excluded
// ***************************************************************
`define CSK_OP_LT 7'h30
`define CSK_OP_EQ 7'h31
`define CSK_OP_GT 7'h32

// ***************************************************************
// addressing and timing
// ***************************************************************
`define CSK_ACC_SPLIT 8'h60
`define CSK_IDX_LIMIT 8'h5F
`define CSK_Q_LAST 2'h3
`define CSK_RST_WORDS 2'h1

`endif

// ==== rtl/csk_pkg.sv ====
// types shared by the compare-skip decoder
package csk_pkg;

	// execution sequencer states
	typedef enum logic [1:0] {CSK_IDLE, CSK_EXEC, CSK_NOP} csk_state_t;

	// decoded instruction class
	typedef enum logic [1:0] {CSK_K_LT, CSK_K_EQ, CSK_K_GT, CSK_K_BAD} csk_kind_t;

endpackage : csk_pkg

// ==== tb/tb_top.sv ====
// self-checking testbench of the compare-skip decoder, driven over apb
`timescale 1ns/1ps
`include "csk_map.svh"

module tb_top;
	import csk_pkg::*;

	// ***************************************************************
	// clock, reset and design connections
	// ***************************************************************
	logic pclk; // 250 mhz bus clock
	logic presetn; // async reset, active low
	logic psel, penable, pwrite; // apb controls
	logic [11:0] paddr; // apb byte address
	logic [31:0] pwdata; // apb write data
	logic [31:0] prdata; // apb read data
	logic pready, pslverr; // apb answer
	logic [13:0] mem_addr; // data memory address
	logic mem_rd; // data memory read strobe
	logic [7:0] mem_rdata; // data memory byte
	logic [1:0] q_phase; // q phase counter
	logic busy, nop_cycle, skip, done; // execution status
	logic [7:0] data_v; // byte served by the memory stand-in
	int mismatches; // wrong values seen
	int check_count; // comparisons made

	csk_decode DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .q_phase(q_phase),
		.busy(busy), .nop_cycle(nop_cycle), .skip(skip), .done(done));

	// free running clock, 4 ns period
	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	// memory stand-in: the byte is only valid in the clock after the strobe,
	// its inverse otherwise, so a read taken at the wrong clock shows up
	always @(posedge pclk)
		mem_rdata <= mem_rd ? data_v : ~data_v;

	// ***************************************************************
	// checking and closing
	// ***************************************************************
	task chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task final_report;
		if (mismatches == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report

	// ***************************************************************
	// apb master: setup, access held until pready, release at that edge
	// ***************************************************************
	task apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd, output logic [31:0] rd,
		output logic err);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			mismatches++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task wr(input logic [11:0] addr, input logic [31:0] wd);
		logic [31:0] d;
		logic e;
		apb(1'b1, addr, wd, d, e);
	endtask : wr

	// read a word and compare both data and error flag
	task rd_chk(input logic [11:0] addr, input logic [31:0] exp, input logic exp_err);
		logic [31:0] d;
		logic e;
		apb(1'b0, addr, 32'h0000_0000, d, e);
		chk(d, exp);
		chk({31'h0, e}, {31'h0, exp_err});
	endtask : rd_chk

	// ***************************************************************
	// one compare-skip instruction, expectations worked out here
	// ***************************************************************
	task run(input int kind, input logic [7:0] w, input logic [7:0] d, input logic a, input logic [7:0] f,
		input logic ext, input logic [1:0] nxt);
		logic [13:0] idx;
		logic [13:0] exp_addr;
		logic exp_skip;
		int n_cyc, cnt, nops;
		idx = 14'h3FF0;
		data_v = d;
		exp_skip = (kind == 0) ? (d < w) : (kind == 1) ? (d == w) : (d > w);
		n_cyc = exp_skip ? 1 + nxt : 1;
		if (a)
			exp_addr = {6'h15, f};
		else if (ext && f <= 8'h5F)
			exp_addr = idx + {6'h00, f};
		else if (f >= 8'h60)
			exp_addr = {6'h3F, f};
		else
			exp_addr = {6'h00, f};
		wr(`CSK_OFF_WORK, {24'h0000_00, w});
		wr(`CSK_OFF_BANK, 32'h0000_0015);
		wr(`CSK_OFF_INDEX, {18'h0, idx});
		wr(`CSK_OFF_NEXT, {30'h0, nxt});
		wr(`CSK_OFF_INSTR, {16'h0000, `CSK_OP_LT + 7'(kind), a, f});
		wr(`CSK_OFF_CTRL, {30'h0, ext, 1'b1});
		cnt = 0;
		while (mem_rd !== 1'b1 && cnt < 20)
		begin
			@(posedge pclk);
			cnt++;
		end
		chk({18'h0, mem_addr}, {18'h0, exp_addr});
		chk({30'h0, q_phase}, 32'h0000_0001);
		cnt = 0;
		nops = 0;
		do
		begin
			@(posedge pclk);
			cnt++;
			if (cnt == 1)
				chk({30'h0, q_phase}, 32'h0000_0002);
			if (nop_cycle === 1'b1)
				nops++;
		end
		while (done !== 1'b1 && cnt < 40);
		chk(cnt, 4 * n_cyc - 1);
		chk(nops, 4 * (n_cyc - 1));
		chk({31'h0, skip}, {31'h0, exp_skip});
		rd_chk(`CSK_OFF_STAT, (n_cyc << 8) | (exp_skip << 2) | 32'h0000_0002, 1'b0);
		rd_chk(`CSK_OFF_WORK, {24'h0000_00, w}, 1'b0);
	endtask : run

	// ***************************************************************
	// main sequence
	// ***************************************************************
	logic [7:0] f_tab [4] = '{8'h5F, 8'h60, 8'h00, 8'hFF}; // addressing boundaries
	int i, k;

	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		data_v = 8'h00;
		mismatches = 0;
		check_count = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		// reset values and unmapped access
		rd_chk(`CSK_OFF_CTRL, 32'h0000_0000, 1'b0);
		rd_chk(`CSK_OFF_INSTR, 32'h0000_0000, 1'b0);
		rd_chk(`CSK_OFF_WORK, 32'h0000_0000, 1'b0);
		rd_chk(`CSK_OFF_NEXT, 32'h0000_0001, 1'b0);
		rd_chk(`CSK_OFF_STAT, 32'h0000_0000, 1'b0);
		wr(12'h01C, 32'hFFFF_FFFF);
		rd_chk(12'h01C, 32'h0000_0000, 1'b1);
		wr(`CSK_OFF_WORK, 32'hFFFF_FFA5);
		rd_chk(`CSK_OFF_WORK, 32'h0000_00A5, 1'b0);
		// every opcode against below, equal, above and the sign boundary
		for (i = 0; i < 12; i++)
		begin
			k = i % 3;
			// f steps every third call so the bank-select path meets every address boundary
			run(k, 8'h7F, 8'h7E + 8'(i / 3), i[0], f_tab[(i / 3) % 4], i[1], 2'((i / 4) % 3 + 1));
		end
		// foreign opcode: one cycle, no skip, write to working register refused while busy
		wr(`CSK_OFF_WORK, 32'h0000_0033);
		wr(`CSK_OFF_INSTR, 32'h0000_6A10);
		wr(`CSK_OFF_CTRL, 32'h0000_0001);
		wr(`CSK_OFF_WORK, 32'h0000_0055);
		i = 0;
		while (busy === 1'b1 && i < 40)
		begin
			@(posedge pclk);
			i++;
		end
		rd_chk(`CSK_OFF_WORK, 32'h0000_0033, 1'b0);
		rd_chk(`CSK_OFF_STAT, 32'h0000_010A, 1'b0);
		wr(`CSK_OFF_STAT, 32'h0000_0002);
		rd_chk(`CSK_OFF_STAT, 32'h0000_0108, 1'b0);
		final_report;
	end

	// watchdog: the whole sequence needs well under 200 us
	initial
	begin
		#200000;
		mismatches++;
		final_report;
	end

endmodule : tb_top
